// ### logic/apc_pkg.sv
// Purpose: shared constants for the converter power, init and read-out control
// Assumes: system clock of 25 MHz
// Notes: times are kept in their own units; cycle counts derive from them
package apc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int INIT_PULSES = 66;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYC = (CONV_TIME_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int PWRUP_TIME_NS = 1000;
  localparam int PWRUP_CYC = (PWRUP_TIME_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int REF_SETTLE_MS = 50;
  localparam int REF_SETTLE_CYC = REF_SETTLE_MS * (CLK_HZ / 1000);
  localparam int RESULT_BITS = 16;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [6:0] CNT_RST = 7'h00;
  localparam int CFG_REF_EN_BIT = 0;
  localparam int CFG_SLEEP_BIT = 1;
  typedef enum logic [1:0] {
    APC_UNINIT = 2'b00,
    APC_IDLE = 2'b01,
    APC_CONV = 2'b11,
    APC_PWRUP = 2'b10
  } apc_state_t;
endpackage

// ### logic/apc_top.sv
// Purpose: power-on init by trigger pulses, conversion, read-out, power-down
// Assumes: trigger and spi pins are asynchronous and sampled by three flops
// Notes: the analog core is outside; this block starts it and takes its data
`timescale 1ns/1ps
module apc_top #(
  parameter int PULSES = apc_pkg::INIT_PULSES
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CONV_TRIGGER_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic CFG_SLEEP,
  input wire logic CFG_REF_EN,
  input wire logic SW_RESET,
  input wire logic [11:0] ADC_DATA,
  output logic INITIALIZED,
  output logic SAMPLE_HOLD,
  output logic CONV_DONE,
  output logic ANALOG_ON,
  output logic REF_ON,
  output logic RO_CLEAR,
  output logic SDO_O,
  output logic SDO_OE,
  output logic [apc_pkg::RESULT_BITS-1:0] RESULT
);
  import apc_pkg::*;

  // falling edge seen between the second and third synchroniser flops
  function automatic logic edge_fall(input logic [2:0] sync);
    return sync[2] & ~sync[1];
  endfunction

  // rising edge seen between the second and third synchroniser flops
  function automatic logic edge_rise(input logic [2:0] sync);
    return ~sync[2] & sync[1];
  endfunction

  // all state of the block in one word, so one process registers it;
  // synchronisers, sequencer, counters and the serial shifter live here
  // and share a single synchronous reset
  typedef struct packed {
    logic [2:0] trg_s;
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    apc_state_t state;
    logic [6:0] pulses;
    logic [4:0] cnt;
    logic pd_req;
    logic in_pd;
    logic [15:0] result;
    logic [15:0] shreg;
    logic init;
    logic hold;
    logic done;
    logic aon;
    logic ron;
    logic roclr;
    logic sdo;
    logic sdo_oe;
  } apc_st_t;

  // current and next copy of the state word, plus decoded pin edges
  // that every branch of the next-state logic can read
  apc_st_t s_reg;
  apc_st_t s_next;
  logic trg_fall;
  logic trg_rise;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;

  // edge detect uses only the second and third flops, so the first flop
  // may settle from metastability without any logic reading it
  assign trg_fall = edge_fall(s_reg.trg_s);
  assign trg_rise = edge_rise(s_reg.trg_s);
  assign cs_fall = edge_fall(s_reg.cs_s);
  assign cs_rise = edge_rise(s_reg.cs_s);
  assign sck_fall = edge_fall(s_reg.sck_s);

  // next state of the whole block; one-cycle strobes default low here
  // so that no path leaves them standing for a second cycle
  always_comb begin
    s_next = s_reg;
    s_next.trg_s = {s_reg.trg_s[1:0], CONV_TRIGGER_N};
    s_next.cs_s = {s_reg.cs_s[1:0], CS_N};
    s_next.sck_s = {s_reg.sck_s[1:0], SCLK};
    s_next.done = 1'b0;
    s_next.roclr = 1'b0;
    // full power-down request and reference control
    s_next.pd_req = CFG_SLEEP & ~CFG_REF_EN;
    s_next.ron = s_reg.init & (CFG_REF_EN | ~s_reg.in_pd);
    unique case (s_reg.state)
      APC_UNINIT: begin
        // rises only count here; no conversion and no read-out yet, so a
        // host sending the init train never sees stray conversions
        // count completed pulses; a pulse ends on its rising edge
        if (trg_rise) begin
          if (s_reg.pulses == 7'(PULSES - 1)) begin
            s_next.state = APC_IDLE;
            s_next.init = 1'b1;
            s_next.pulses = CNT_RST;
          end else begin
            s_next.pulses = s_reg.pulses + 7'h01;
          end
        end
      end
      APC_IDLE: begin
        // wake has priority so a rising edge after the bits are cleared
        // is never lost; power-down entry beats a new conversion, and a
        // fall while powered down is ignored
        if (s_reg.in_pd && !s_reg.pd_req && trg_rise) begin
          s_next.state = APC_PWRUP;
          s_next.cnt = 5'h00;
        end else if (s_reg.pd_req && !s_reg.in_pd) begin
          s_next.in_pd = 1'b1;
          s_next.aon = 1'b0;
        end else if (trg_fall && !s_reg.in_pd) begin
          s_next.state = APC_CONV;
          s_next.hold = 1'b1;
          s_next.cnt = 5'h00;
        end
      end
      APC_CONV: begin
        // fixed conversion length from the internal clock; the trigger
        // level is looked at only on the last count
        if (s_reg.cnt == 5'(CONV_CYC - 1)) begin
          s_next.state = APC_IDLE;
          s_next.hold = 1'b0;
          s_next.done = 1'b1;
          s_next.result = {4'h0, ADC_DATA};
          // trigger still low at end of conversion: drop to power-down
          if (!s_reg.trg_s[2]) begin
            s_next.in_pd = 1'b1;
            s_next.aon = 1'b0;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 5'h01;
        end
      end
      APC_PWRUP: begin
        // analog stays off until the whole power-up time has run, so a
        // conversion can never start on a half-powered core
        if (s_reg.cnt == 5'(PWRUP_CYC - 1)) begin
          s_next.state = APC_IDLE;
          s_next.in_pd = 1'b0;
          s_next.aon = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 5'h01;
        end
      end
      default: s_next.state = APC_UNINIT;
    endcase
    // software reset clears the read-only result to its default; it is
    // placed after the capture so a clear in the same cycle wins
    if (s_reg.init && SW_RESET) begin
      s_next.result = RESULT_RST;
      s_next.roclr = 1'b1;
    end
    // serial read-out, alive in power-down, dead before init; the frame
    // loads from the result register on chip-select fall, so a capture
    // during a frame only shows in the next one
    if (s_reg.init) begin
      if (cs_fall) begin
        s_next.shreg = {s_reg.result[14:0], 1'b0};
        s_next.sdo = s_reg.result[15];
        s_next.sdo_oe = 1'b1;
      end else if (cs_rise) begin
        s_next.sdo_oe = 1'b0;
      end else if (sck_fall && !s_reg.cs_s[2]) begin
        s_next.sdo = s_reg.shreg[15];
        s_next.shreg = {s_reg.shreg[14:0], 1'b0};
      end
    end
  end

  // register the state; synchronisers reset to the idle level of their
  // pins so release of reset never shows a false edge; analog starts on
  // so the first conversion after init needs no wake-up
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      s_reg <= '{trg_s: 3'h7, cs_s: 3'h7, sck_s: 3'h0,
                 state: APC_UNINIT, pulses: CNT_RST, cnt: 5'h00,
                 pd_req: 1'b0, in_pd: 1'b0, result: RESULT_RST,
                 shreg: RESULT_RST, init: 1'b0, hold: 1'b0,
                 done: 1'b0, aon: 1'b1, ron: 1'b0, roclr: 1'b0,
                 sdo: 1'b0, sdo_oe: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops; no output has logic after its register
  // so all of them are glitch free towards the pins and the core
  assign INITIALIZED = s_reg.init;
  assign SAMPLE_HOLD = s_reg.hold;
  assign CONV_DONE = s_reg.done;
  assign ANALOG_ON = s_reg.aon;
  assign REF_ON = s_reg.ron;
  assign RO_CLEAR = s_reg.roclr;
  assign SDO_O = s_reg.sdo;
  assign SDO_OE = s_reg.sdo_oe;
  assign RESULT = s_reg.result;
endmodule

// ### verification/apc_top_asserts.sv
// Purpose: port timing checks for apc_top
// Assumes: one clock domain, synchronous reset
// Notes: bound to every apc_top instance
`timescale 1ns/1ps
module apc_asserts (
  input wire logic CLK_SYS, RESET_N, CONV_TRIGGER_N, CS_N, CFG_SLEEP,
  input wire logic CFG_REF_EN, SW_RESET, INITIALIZED, SAMPLE_HOLD,
  input wire logic CONV_DONE, ANALOG_ON, REF_ON, RO_CLEAR, SDO_O, SDO_OE,
  input wire logic [11:0] ADC_DATA,
  input wire logic [15:0] RESULT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // conversion length, result capture and read-out start
  a_hold_time: assert property (
    $rose(SAMPLE_HOLD) |-> ##14 SAMPLE_HOLD ##1 !SAMPLE_HOLD && CONV_DONE)
    else $error("conversion length wrong");
  a_result_load: assert property (
    CONV_DONE |-> RESULT == {4'h0, $past(ADC_DATA)}) else $error("result");
  a_msb_first: assert property (
    $rose(SDO_OE) |-> SDO_O == RESULT[15] && !$past(CS_N, 2))
    else $error("first bit");
  // nothing answers before the pulse count is reached
  a_init_gate: assert property (
    !INITIALIZED |-> !SAMPLE_HOLD && !SDO_OE) else $error("not gated");
  a_sw_clear: assert property (
    SW_RESET && INITIALIZED |=> RO_CLEAR) else $error("no clear");
  // power-down entry, reference hold and exit
  a_full_down: assert property (
    (INITIALIZED && CFG_SLEEP && !CFG_REF_EN && !SAMPLE_HOLD) [*4] |->
    !ANALOG_ON && !REF_ON) else $error("still powered");
  a_ref_kept: assert property (
    (CFG_REF_EN && INITIALIZED) [*3] |-> REF_ON) else $error("ref off");
  a_wake_edge: assert property (
    $rose(ANALOG_ON) |-> $past(CONV_TRIGGER_N, 25) &&
    !$past(CONV_TRIGGER_N, 32)) else $error("wake timing");
endmodule
bind apc_top apc_asserts u_chk (.*);

// ### verification/apc_host.sv
// Purpose: host side model, trigger pulses and spi reads
// Assumes: spi clock idles low and runs only inside frames
// Notes: a released data line reads as the inverse of its last bit
`timescale 1ns/1ps
module apc_host (
  input wire logic clk,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  output logic trig_n,
  output logic cs_n,
  output logic sclk
);
  logic last = 1'b0;
  wire sdo = sdo_oe ? sdo_o : ~last;
  initial {trig_n, cs_n, sclk} = 3'b110;
  // remember the last driven bit
  always @(posedge clk) if (sdo_oe) last <= sdo_o;
  // wait cycles, then step just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one trigger pulse, raised early, spaced by 2 us
  task automatic pulse();
    trig_n = 0;
    w(5);
    trig_n = 1;
    w(50);
  endtask
  // 16-bit read, each bit taken before the next clock fall
  task automatic read(output logic [15:0] d);
    cs_n = 0;
    w(8);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1;
      w(4);
      d[i] = sdo;
      sclk = 0;
      w(4);
    end
    cs_n = 1;
    w(8);
  endtask
endmodule

// ### verification/adc_power_mode_init_control_tb_top.sv
// Purpose: self-checking bench for apc_top
// Assumes: 25 MHz clock, shortened init count
// Notes: random data from a fixed seed
`timescale 1ns/1ps
module adc_power_mode_init_control_tb_top;
  localparam int NP = 6;
  logic CLK_SYS = 0, RESET_N = 0, CFG_SLEEP = 0, CFG_REF_EN = 0;
  logic SW_RESET = 0, CONV_TRIGGER_N, CS_N, SCLK, INITIALIZED, SAMPLE_HOLD;
  logic CONV_DONE, ANALOG_ON, REF_ON, RO_CLEAR, SDO_O, SDO_OE;
  logic [11:0] ADC_DATA = 12'h000;
  logic [15:0] RESULT, d;
  int fail_count = 0, checks = 0;
  integer seed = 32'h8ee96eba;
  apc_top #(.PULSES(NP)) DUT (.*);
  apc_host host (.clk(CLK_SYS), .sdo_o(SDO_O), .sdo_oe(SDO_OE),
    .trig_n(CONV_TRIGGER_N), .cs_n(CS_N), .sclk(SCLK));
  initial forever #20 CLK_SYS = ~CLK_SYS;
  // compare and count
  task automatic chk(input string n, input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end
  // main sequence
  initial begin
    host.w(10);
    RESET_N = 1;
    chk("analog", ANALOG_ON, 1);
    repeat (NP - 1) host.pulse();
    chk("early", INITIALIZED, 0);
    host.read(d);
    chk("ignored", d, 16'hffff);
    host.pulse();
    chk("ready", INITIALIZED, 1);
    SW_RESET = 1;
    host.w(1);
    SW_RESET = 0;
    chk("ro clear", RO_CLEAR, 1);
    // reference settling is left to the host; only digital data is read
    $display("init test done");
    for (int k = 0; k < 4; k++) begin
      ADC_DATA = k == 0 ? 12'hfff : 12'($random(seed));
      host.pulse();
      chk("result", RESULT, {4'h0, ADC_DATA});
      host.read(d);
      chk("sdo", d, {4'h0, ADC_DATA});
    end
    $display("conversion test done");
    {CFG_SLEEP, CFG_REF_EN} = 2'b11;
    host.w(5);
    chk("ref kept", REF_ON, 1);
    CFG_REF_EN = 0;
    host.w(5);
    chk("analog off", ANALOG_ON, 0);
    chk("ref off", REF_ON, 0);
    host.read(d);
    chk("pd read", d, {4'h0, ADC_DATA});
    CFG_SLEEP = 0;
    host.w(5);
    chk("wait edge", ANALOG_ON, 0);
    host.pulse();
    chk("awake", ANALOG_ON, 1);
    $display("power test done");
    stop_test();
  end
endmodule
